/* File: include/lpmc_pkg.sv */
// Constants shared by the low power mode controller and its clock dividers.
// Assumes one system clock and a CPU that signals execution of its wait
// instruction as a one-cycle pulse.
//
// What this block does
// - Software sets a divide ratio for the core, the four peripheral, the external bus and the flash interface clocks, each on its own.
// - Software chooses whether the external bus clock pin toggles with the bus clock or sits high.
// - Each peripheral module has its own stop bit that halts that module only.
// - There are exactly four low power states: sleep, all-module clock stop, software standby and deep software standby.
// - Software picks the target state in a register and the state is entered only when the wait instruction executes.
// - In sleep and all-module clock stop an interrupt ends the state and the CPU resumes with that interrupt's handling.
// - Every low power state halts the CPU, with its registers kept in all but deep software standby, and some states also halt peripherals or oscillators.
// - The USB host/function unit may run in sleep but is stopped in all-module clock stop, where RAM and flash halt with contents kept.
// - The voltage detector may keep running in sleep and all-module clock stop, and the power-on reset circuit always runs.
// - Both eight-bit timer units may keep counting in sleep so they can wake the device.
// - In all-module clock stop the watchdog is halted with its state kept while the independent watchdog may keep running.
package lpmc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CLKDIV_OFS = 8'h00;
  localparam logic [7:0] MSTOP_OFS = 8'h04;
  localparam logic [7:0] LPCTRL_OFS = 8'h08;
  localparam logic [7:0] LPSTAT_OFS = 8'h0C;

  localparam logic [31:0] CLKDIV_RST = 32'h0000_0000;
  localparam logic [31:0] MSTOP_RST = 32'h0000_0000;
  localparam logic [31:0] LPCTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LPCTRL_MASK = 32'h0000_01F3;

  // ==========================================================================
  // Clock divide fields, four bits per clock in CLKDIV
  localparam int NCLK = 7;
  localparam int CK_CORE = 0;
  localparam int CK_PA = 1;
  localparam int CK_PB = 2;
  localparam int CK_PC = 3;
  localparam int CK_PD = 4;
  localparam int CK_BUS = 5;
  localparam int CK_FLASH = 6;
  localparam int DIV_FW = 4;
  localparam int PIN_HIGH_BIT = 28;
  localparam logic [3:0] DIV_MAX = 4'h6;
  localparam int DIV_CNT_W = 6;

  // ==========================================================================
  // LPCTRL fields
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_ALLCLK = 2'h1;
  localparam logic [1:0] MODE_SWSTBY = 2'h2;
  localparam logic [1:0] MODE_DEEP = 2'h3;
  localparam int KEEP_LVD_BIT = 4;
  localparam int KEEP_IWDT_BIT = 5;
  localparam int KEEP_TMR0_BIT = 6;
  localparam int KEEP_TMR1_BIT = 7;
  localparam int KEEP_USB_BIT = 8;

  // ==========================================================================
  // LPSTAT fields and state codes
  localparam int HALT_BIT = 4;
  localparam logic [2:0] STC_RUN = 3'h0;
  localparam logic [2:0] STC_SLEEP = 3'h1;
  localparam logic [2:0] STC_ALLCLK = 3'h2;
  localparam logic [2:0] STC_SWSTBY = 3'h3;
  localparam logic [2:0] STC_DEEP = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: verilog/lpmc_clk_div.sv */
// Power-of-two clock enable divider for one derived clock.
// Assumes ratio_i holds a code from 0 to the largest legal one.
`timescale 1ns/1ns
module lpmc_clk_div (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] ratio_i,
  input wire logic run_i,
  output logic tick_o
);

  logic [lpmc_pkg::DIV_CNT_W-1:0] cnt_reg;
  logic [lpmc_pkg::DIV_CNT_W-1:0] mask;
  logic tick_reg;

  // Code n gives one enable every 2**n clocks
  assign mask = lpmc_pkg::DIV_CNT_W'((7'h01 << ratio_i) - 7'h01);
  assign tick_o = tick_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (run_i) begin
      cnt_reg <= cnt_reg + 1'b1;
      tick_reg <= (cnt_reg & mask) == mask;
    end else begin
      // Stopped clock keeps its phase so a resume is glitch free
      tick_reg <= 1'b0;
    end
  end

  chk_div_period: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (run_i && ratio_i == 4'h1 && $past(run_i) && $past(ratio_i) == 4'h1
      && tick_o) |=> (run_i ? !tick_o : 1'b1))
    else $error("divide by two gave back to back enables");

endmodule // lpmc_clk_div

/* File: verilog/lpmc_ctrl.sv */
// Low power mode controller: clock dividers, module stop, low power states.
// Assumes an AXI4-Lite master, a CPU that pulses wait_exec_i on its wait
// instruction and an interrupt controller that holds irq_i while pending.
`timescale 1ns/1ns
module lpmc_ctrl (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU and interrupt controller
  input wire logic wait_exec_i,
  input wire logic irq_i,
  output logic cpu_halt_o,
  output logic reset_req_o,
  // Clock enables and the external bus clock pin
  output logic core_clock_en_o,
  output logic [3:0] periph_clock_en_o,
  output logic bus_clock_en_o,
  output logic flash_if_clock_en_o,
  output logic bus_clock_pin_o,
  // Unit run controls
  output logic [31:0] module_run_o,
  output logic ram_run_o,
  output logic flash_run_o,
  output logic usb_host_function_unit_run_o,
  output logic [1:0] eight_bit_timer_run_o,
  output logic watchdog_unit_run_o,
  output logic independent_watchdog_unit_run_o,
  output logic voltage_detector_run_o,
  output logic por_run_o,
  output logic main_osc_run_o
);

  // ==========================================================================
  // Registers and state
  typedef enum logic [2:0] {
    ST_RUN, ST_SLEEP, ST_ALLCLK, ST_SWSTBY, ST_DEEP
  } lpmc_state_e;

  lpmc_state_e state_reg;
  lpmc_state_e state_next;
  logic [31:0] clkdiv_reg;
  logic [31:0] mstop_reg;
  logic [31:0] lpctrl_reg;
  logic pin_reg;
  logic reset_req_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Prohibited ratio codes leave the old ratio in place
  function automatic logic [31:0] clean_div(input logic [31:0] old_v,
                                            input logic [31:0] new_v);
    logic [31:0] res;
    res = '0;
    for (int c = 0; c < lpmc_pkg::NCLK; c++) begin
      if (new_v[lpmc_pkg::DIV_FW*c +: 4] <= lpmc_pkg::DIV_MAX) begin
        res[lpmc_pkg::DIV_FW*c +: 4] = new_v[lpmc_pkg::DIV_FW*c +: 4];
      end else begin
        res[lpmc_pkg::DIV_FW*c +: 4] = old_v[lpmc_pkg::DIV_FW*c +: 4];
      end
    end
    res[lpmc_pkg::PIN_HIGH_BIT] = new_v[lpmc_pkg::PIN_HIGH_BIT];
    return res;
  endfunction

  // ==========================================================================
  // Bus decode
  logic wr_go;
  logic rd_go;
  logic wr_clkdiv;
  logic wr_mstop;
  logic wr_lpctrl;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] wr_merged;
  logic [31:0] rd_mux;
  logic [2:0] st_code;
  logic [31:0] lpstat_val;

  // Address and data are taken together; holding ready low until both
  // are offered keeps the slave free of a half-done write.
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_go = s_axi_arvalid && !rvalid_reg;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  assign wr_clkdiv = wr_go && s_axi_awaddr == lpmc_pkg::CLKDIV_OFS;
  assign wr_mstop = wr_go && s_axi_awaddr == lpmc_pkg::MSTOP_OFS;
  assign wr_lpctrl = wr_go && s_axi_awaddr == lpmc_pkg::LPCTRL_OFS;
  assign wr_hit = wr_clkdiv || wr_mstop || wr_lpctrl ||
                  s_axi_awaddr == lpmc_pkg::LPSTAT_OFS;
  assign rd_hit = s_axi_araddr == lpmc_pkg::CLKDIV_OFS ||
                  s_axi_araddr == lpmc_pkg::MSTOP_OFS ||
                  s_axi_araddr == lpmc_pkg::LPCTRL_OFS ||
                  s_axi_araddr == lpmc_pkg::LPSTAT_OFS;

  assign st_code = (state_reg == ST_SLEEP) ? lpmc_pkg::STC_SLEEP :
                   (state_reg == ST_ALLCLK) ? lpmc_pkg::STC_ALLCLK :
                   (state_reg == ST_SWSTBY) ? lpmc_pkg::STC_SWSTBY :
                   (state_reg == ST_DEEP) ? lpmc_pkg::STC_DEEP :
                   lpmc_pkg::STC_RUN;
  assign lpstat_val = {27'h0, cpu_halt_o, 1'b0, st_code};

  assign rd_mux =
    (s_axi_araddr == lpmc_pkg::CLKDIV_OFS) ? clkdiv_reg :
    (s_axi_araddr == lpmc_pkg::MSTOP_OFS) ? mstop_reg :
    (s_axi_araddr == lpmc_pkg::LPCTRL_OFS) ? lpctrl_reg :
    (s_axi_araddr == lpmc_pkg::LPSTAT_OFS) ? lpstat_val : 32'h0000_0000;

  assign wr_merged = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);

  // ==========================================================================
  // Bus response channels
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= lpmc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? lpmc_pkg::RESP_OKAY : lpmc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= lpmc_pkg::RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? lpmc_pkg::RESP_OKAY : lpmc_pkg::RESP_SLVERR;
      rdata_reg <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clkdiv_reg <= lpmc_pkg::CLKDIV_RST;
      mstop_reg <= lpmc_pkg::MSTOP_RST;
      lpctrl_reg <= lpmc_pkg::LPCTRL_RST;
    end else begin
      if (wr_clkdiv) begin
        clkdiv_reg <= clean_div(clkdiv_reg,
                        merge(clkdiv_reg, s_axi_wdata, s_axi_wstrb));
      end
      if (wr_mstop) begin
        mstop_reg <= merge(mstop_reg, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_lpctrl) begin
        lpctrl_reg <= merge(lpctrl_reg, wr_merged | (lpctrl_reg &
                        ~{{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                          {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}}),
                        s_axi_wstrb) & lpmc_pkg::LPCTRL_MASK;
      end
    end
  end

  // ==========================================================================
  // Low power state machine
  logic [1:0] mode_sel;
  assign mode_sel = lpctrl_reg[lpmc_pkg::MODE_LSB +: 2];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (wait_exec_i) begin
          unique case (mode_sel)
            lpmc_pkg::MODE_SLEEP: state_next = ST_SLEEP;
            lpmc_pkg::MODE_ALLCLK: state_next = ST_ALLCLK;
            lpmc_pkg::MODE_SWSTBY: state_next = ST_SWSTBY;
            lpmc_pkg::MODE_DEEP: state_next = ST_DEEP;
          endcase
        end
      end
      ST_SLEEP, ST_ALLCLK, ST_SWSTBY, ST_DEEP: begin
        if (irq_i) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  // Reset always wins over every state, including the deep one
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_RUN;
      reset_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Deep standby lost CPU context, so waking goes via reset processing
      reset_req_reg <= state_reg == ST_DEEP && irq_i;
    end
  end
  assign reset_req_o = reset_req_reg;

  // ==========================================================================
  // Run controls per state
  logic in_run;
  logic in_sleep;
  logic in_allclk;
  logic in_swstby;
  logic periph_on;
  logic keep_lvd;
  logic keep_iwdt;
  logic keep_usb;
  logic [1:0] keep_tmr;

  assign in_run = state_reg == ST_RUN;
  assign in_sleep = state_reg == ST_SLEEP;
  assign in_allclk = state_reg == ST_ALLCLK;
  assign in_swstby = state_reg == ST_SWSTBY;
  assign keep_lvd = lpctrl_reg[lpmc_pkg::KEEP_LVD_BIT];
  assign keep_iwdt = lpctrl_reg[lpmc_pkg::KEEP_IWDT_BIT];
  assign keep_usb = lpctrl_reg[lpmc_pkg::KEEP_USB_BIT];
  assign keep_tmr = {lpctrl_reg[lpmc_pkg::KEEP_TMR1_BIT],
                     lpctrl_reg[lpmc_pkg::KEEP_TMR0_BIT]};

  assign periph_on = in_run || in_sleep;
  assign cpu_halt_o = !in_run;
  assign module_run_o = {32{periph_on}} & ~mstop_reg;
  assign ram_run_o = periph_on;
  assign flash_run_o = periph_on;
  assign usb_host_function_unit_run_o = in_run || (in_sleep && keep_usb);
  assign eight_bit_timer_run_o = {2{in_run}} |
    ({2{in_sleep || in_allclk}} & keep_tmr);
  assign watchdog_unit_run_o = in_run;
  assign independent_watchdog_unit_run_o = in_run ||
    ((in_sleep || in_allclk || in_swstby) && keep_iwdt);
  assign voltage_detector_run_o = in_run || keep_lvd;
  assign por_run_o = 1'b1;
  assign main_osc_run_o = in_run || in_sleep || in_allclk;

  // ==========================================================================
  // Clock dividers
  logic [lpmc_pkg::NCLK-1:0] div_run;
  logic [lpmc_pkg::NCLK-1:0] div_tick;

  assign div_run[lpmc_pkg::CK_CORE] = in_run;
  assign div_run[lpmc_pkg::CK_PA] = periph_on;
  assign div_run[lpmc_pkg::CK_PB] = periph_on;
  assign div_run[lpmc_pkg::CK_PC] = periph_on;
  assign div_run[lpmc_pkg::CK_PD] = periph_on;
  assign div_run[lpmc_pkg::CK_BUS] = periph_on;
  assign div_run[lpmc_pkg::CK_FLASH] = periph_on;

  genvar gi;
  generate
    for (gi = 0; gi < lpmc_pkg::NCLK; gi++) begin : g_div
      lpmc_clk_div u_div (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ratio_i(clkdiv_reg[lpmc_pkg::DIV_FW*gi +: 4]),
        .run_i(div_run[gi]),
        .tick_o(div_tick[gi])
      );
    end
  endgenerate

  assign core_clock_en_o = div_tick[lpmc_pkg::CK_CORE];
  assign periph_clock_en_o = div_tick[lpmc_pkg::CK_PD:lpmc_pkg::CK_PA];
  assign bus_clock_en_o = div_tick[lpmc_pkg::CK_BUS];
  assign flash_if_clock_en_o = div_tick[lpmc_pkg::CK_FLASH];

  // ==========================================================================
  // External bus clock pin
  logic pin_high;
  assign pin_high = clkdiv_reg[lpmc_pkg::PIN_HIGH_BIT];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_reg <= 1'b1;
    end else if (pin_high) begin
      pin_reg <= 1'b1;
    end else if (div_tick[lpmc_pkg::CK_BUS]) begin
      pin_reg <= !pin_reg;
    end
  end
  assign bus_clock_pin_o = pin_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_wait_only_entry: assert property (
    (in_run && !wait_exec_i) |=> in_run)
    else $error("left run state without a wait instruction");

  chk_wait_sleep: assert property (
    (in_run && wait_exec_i && mode_sel == lpmc_pkg::MODE_SLEEP)
      |=> in_sleep && cpu_halt_o)
    else $error("wait with sleep selected did not enter sleep");

  chk_irq_wake: assert property (
    ((in_sleep || in_allclk) && irq_i) |=> !cpu_halt_o)
    else $error("interrupt did not resume the cpu");

  chk_halt_held: assert property (
    (!in_run && !irq_i) |=> cpu_halt_o && !core_clock_en_o)
    else $error("cpu ran in a low power state");

  chk_allclk_stops: assert property (
    in_allclk |-> !usb_host_function_unit_run_o && !ram_run_o
      && !flash_run_o && module_run_o == 32'h0000_0000)
    else $error("unit running in all-module clock stop");

  chk_lvd_keep: assert property (
    ((in_sleep || in_allclk) && keep_lvd) |-> voltage_detector_run_o
      && por_run_o)
    else $error("voltage detector halted while kept");

  chk_tmr_sleep: assert property (
    (in_sleep && keep_tmr == 2'h3) |-> eight_bit_timer_run_o == 2'h3)
    else $error("timer stopped in sleep while kept");

  chk_wdt_allclk: assert property (
    in_allclk |-> !watchdog_unit_run_o
      && independent_watchdog_unit_run_o == keep_iwdt)
    else $error("watchdog control wrong in all-module clock stop");

  chk_reset_exit: assert property (
    $past(sys_rst_i) |-> in_run && !cpu_halt_o && !reset_req_o)
    else $error("reset did not restart in run state");

  chk_deep_wake: assert property (
    (state_reg == ST_DEEP && irq_i) |=> reset_req_o ##1 !reset_req_o)
    else $error("deep standby wake did not pulse reset request");

  // Two cycles of the select are needed: a clear in the second cycle may
  // let the pin toggle again in the one after
  chk_pin_high: assert property (
    pin_high [*2] |-> bus_clock_pin_o [*2])
    else $error("bus clock pin toggled while held high");

  chk_mstop_one: assert property (
    (periph_on && $rose(mstop_reg[0]) && !$changed(mstop_reg[31:1]))
      |-> !module_run_o[0] && module_run_o[31:1] == ~mstop_reg[31:1])
    else $error("module stop affected other modules");

endmodule // lpmc_ctrl

/* File: sim/lpmc_cpu_model.sv */
// Behavioural CPU core and interrupt controller facing the controller.
// Assumes the bench asks for a wait instruction by pulsing do_wait_i.
`timescale 1ns/1ns
module lpmc_cpu_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic do_wait_i,
  input wire logic [7:0] irq_delay_i,
  input wire logic cpu_halt_i,
  output logic wait_exec_o,
  output logic irq_o
);
  // ==========================================================================
  // Wait instruction and interrupt source
  logic [7:0] cnt_reg;

  // Delay 0 never wakes, so a reset is the only way out
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_exec_o <= 1'b0;
      irq_o <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      wait_exec_o <= do_wait_i;
      if (!cpu_halt_i) begin
        cnt_reg <= 8'h00;
        irq_o <= 1'b0;
      end else if (irq_delay_i != 8'h00 && cnt_reg == irq_delay_i) begin
        irq_o <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule // lpmc_cpu_model

/* File: sim/tb_top.sv */
// Self-checking bench for the low power mode controller.
// Assumes the CPU model in lpmc_cpu_model.sv and a 20 MHz clock.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  // ==========================================================================
  // Signals
  logic clk_i = 0, sys_rst_i = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, do_wait = 0;
  logic [7:0] awaddr = 0, araddr = 0, irq_delay = 0;
  logic [31:0] wdata = 0, cd, ms, k, x;
  wire awready, wready, bvalid, arready, rvalid, wait_exec, irq, halt;
  wire reset_req, core_en, bus_en, flash_en, pin, ram, flash, usb, wdt;
  wire iwdt, lvd, por, osc;
  wire [1:0] bresp, rresp, tmr;
  wire [3:0] periph_en;
  wire [31:0] rdata, module_run;
  wire [6:0] en_w = {flash_en, bus_en, periph_en, core_en};
  wire [9:0] run_w = {ram, flash, usb, tmr, wdt, iwdt, lvd, por, osc};
  int fails = 0, compares = 0, rq_cnt = 0, c[7], m, n;
  logic [33:0] rq[$], er;
  logic [1:0] bq[$], eb;
  localparam logic [1:0] OK = lpmc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = lpmc_pkg::RESP_SLVERR;

  always #25 clk_i = ~clk_i;

  lpmc_ctrl lpmc_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wait_exec_i(wait_exec),
    .irq_i(irq), .cpu_halt_o(halt), .reset_req_o(reset_req),
    .core_clock_en_o(core_en), .periph_clock_en_o(periph_en),
    .bus_clock_en_o(bus_en), .flash_if_clock_en_o(flash_en),
    .bus_clock_pin_o(pin), .module_run_o(module_run), .ram_run_o(ram),
    .flash_run_o(flash), .usb_host_function_unit_run_o(usb),
    .eight_bit_timer_run_o(tmr), .watchdog_unit_run_o(wdt),
    .independent_watchdog_unit_run_o(iwdt), .voltage_detector_run_o(lvd),
    .por_run_o(por), .main_osc_run_o(osc));

  lpmc_cpu_model lpmc_cpu_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .do_wait_i(do_wait), .irq_delay_i(irq_delay), .cpu_halt_i(halt),
    .wait_exec_o(wait_exec), .irq_o(irq));

  // ==========================================================================
  // Result monitor
  always @(posedge clk_i) begin
    if (rvalid && rready) begin
      er = rq.pop_front();
      `CHK("read", er, {rresp, rdata})
    end
    if (bvalid && bready) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (reset_req) rq_cnt++;
  end

  // ==========================================================================
  // Bus and CPU tasks
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
    bq.push_back(r);
    @(posedge clk_i);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do @(posedge clk_i); while (awready !== 1'b1);
    awvalid <= 0; wvalid <= 0;
    do @(posedge clk_i); while (bvalid !== 1'b1);
    bready <= 0;
  endtask

  task automatic rd(input [7:0] a, input [31:0] d, input [1:0] r);
    rq.push_back({r, d});
    @(posedge clk_i);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rready <= 0;
  endtask

  task automatic enter();
    int i;
    i = 0;
    @(posedge clk_i); do_wait <= 1;
    @(posedge clk_i); do_wait <= 0;
    while (halt !== 1'b1 && i < 8) begin @(posedge clk_i); i++; end
  endtask

  task automatic period(input int i, input int p);
    int t;
    t = 0;
    do @(posedge clk_i); while (en_w[i] !== 1'b1);
    do begin @(posedge clk_i); t++; end while (en_w[i] !== 1'b1);
    `CHK("divide", p, t)
  endtask

  // Window is a whole number of bus periods, so phase does not matter
  task automatic pin_chk(input int p, input int e);
    int t;
    logic last;
    t = 0;
    do @(posedge clk_i); while (bus_en !== 1'b1);
    last = pin;
    repeat (10 * p) begin @(posedge clk_i); t += (pin !== last); last = pin; end
    `CHK("pin toggles", e, t)
  endtask

  function automatic [9:0] exp_run(input int md, input [31:0] kb);
    logic s, a;
    s = (md == 0);
    a = (md == 1);
    return {s, s, s & kb[8], (s | a) ? kb[7:6] : 2'b00, 1'b0,
      (md != 3) & kb[5], kb[4], 1'b1, s | a};
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog and main sequence
  initial begin
    #(60000 * 50);
    fails++;
    conclude();
  end

  initial begin
    void'($urandom(36732));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 0;
    `CHK("module run", 32'hFFFFFFFF, module_run)
    `CHK("pin", 1'b1, pin)
    rd(lpmc_pkg::LPCTRL_OFS, 0, OK);
    rd(8'h10, 0, ERR);
    wr(8'h10, 32'hFFFFFFFF, ERR);
    wr(lpmc_pkg::LPSTAT_OFS, 32'h1F, OK);
    rd(lpmc_pkg::LPSTAT_OFS, 0, OK);
    cd = 0;
    for (int i = 0; i < 7; i++) begin
      // Clock A fixed at divide by two so the divider check gets exercised
      c[i] = (i == 1) ? 1 : $urandom % 7;
      cd |= c[i] << (4 * i);
    end
    wr(lpmc_pkg::CLKDIV_OFS, cd, OK);
    for (int i = 0; i < 7; i++) period(i, 1 << c[i]);
    // Bad core code is dropped while the flash field still updates
    wr(lpmc_pkg::CLKDIV_OFS, {4'h0, cd[23:4], 4'hF}, OK);
    x = {8'h00, cd[23:0]};
    rd(lpmc_pkg::CLKDIV_OFS, x, OK);
    pin_chk(1 << c[5], 10);
    wr(lpmc_pkg::CLKDIV_OFS, x | 32'h10000000, OK);
    pin_chk(1 << c[5], 0);
    `CHK("pin", 1'b1, pin)
    ms = $urandom & 32'hFFFFFFFE;
    wr(lpmc_pkg::MSTOP_OFS, ms, OK);
    rd(lpmc_pkg::MSTOP_OFS, ms, OK);
    `CHK("module run", ~ms, module_run)
    // Stop one more module alone; the others must keep running
    ms[0] = 1'b1;
    wr(lpmc_pkg::MSTOP_OFS, ms, OK);
    `CHK("module run", ~ms, module_run)
    for (m = 0; m < 4; m++) begin
      // Sleep always keeps both timers so their keep path gets exercised
      k = ($urandom & 32'h1F0) | m | ((m == 0) ? 32'hC0 : 32'h0);
      wr(lpmc_pkg::LPCTRL_OFS, k, OK);
      rd(lpmc_pkg::LPCTRL_OFS, k, OK);
      `CHK("halt early", 1'b0, halt)
      irq_delay <= 8'(10 + $urandom % 20);
      enter();
      `CHK("halt", 1'b1, halt)
      `CHK("run set", exp_run(m, k), run_w)
      `CHK("module run", (m == 0) ? ~ms : 32'h0, module_run)
      rd(lpmc_pkg::LPSTAT_OFS, 32'h10 | (m + 1), OK);
      n = rq_cnt;
      for (int i = 0; i < 100 && halt === 1'b1; i++) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      `CHK("halt wake", 1'b0, halt)
      `CHK("reset req", (m == 3) ? n + 1 : n, rq_cnt)
      `CHK("module run", ~ms, module_run)
    end
    irq_delay <= 0;
    wr(lpmc_pkg::LPCTRL_OFS, 32'h1F0, OK);
    enter();
    sys_rst_i <= 1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 0;
    @(posedge clk_i);
    `CHK("halt reset", 1'b0, halt)
    rd(lpmc_pkg::LPSTAT_OFS, 0, OK);
    rd(lpmc_pkg::MSTOP_OFS, 0, OK);
    conclude();
  end
endmodule // tb_top
